// *** inw_pkg.sv ***
// constants, field layouts and types shared by the interrupt nesting and wake-up block
package inw_pkg;
   localparam int INW_NCH       = 8;
   localparam int INW_PW        = 3;
   localparam int INW_FLD_W     = 4;
   localparam int INW_AW        = 8;
   localparam int INW_DW        = 32;

   typedef logic [INW_PW-1:0] inw_prio_t;
   typedef logic [2:0]        inw_chan_t;

   // register byte offsets
   localparam logic [INW_AW-1:0] INW_OFS_PRIO   = 8'h00;
   localparam logic [INW_AW-1:0] INW_OFS_ROUTE  = 8'h04;
   localparam logic [INW_AW-1:0] INW_OFS_STATUS = 8'h08;

   // reset values
   localparam logic [INW_DW-1:0]  INW_PRIO_RST  = 32'h0000_0000;
   localparam logic [INW_NCH-1:0] INW_ROUTE_RST = 8'h00;

   // status field positions
   localparam int INW_ST_PEND_LSB  = 0;
   localparam int INW_ST_DEPTH_LSB = 8;
   localparam int INW_ST_IPL_LSB   = 12;
   localparam int INW_ST_PIN_BIT   = 16;
   localparam int INW_ST_MACH_BIT  = 17;

   localparam logic [2:0] INW_MAX_NEST = 3'h7;
   localparam logic [2:0] INW_DEPTH_RST = 3'h0;
   localparam inw_prio_t  INW_PRIO_ZERO = 3'h0;

   localparam logic [1:0] INW_HTRANS_NONSEQ = 2'h2;
   localparam logic       INW_HRESP_OKAY    = 1'b0;

   typedef enum logic [2:0] {
      INW_VEC_NONE,
      INW_VEC_MACH,
      INW_VEC_PIN,
      INW_VEC_CHAN,
      INW_VEC_SPUR
   } inw_vec_t;
endpackage

// *** inw_chan_qual.sv ***
// per-channel qualification of one maskable request against the core level
`timescale 1ns/100ps
module inw_chan_qual
   import inw_pkg::*;
(
   // request and its configuration
   input  wire logic      req,
   input  wire logic      routed,
   input  inw_pkg::inw_prio_t prio,
   // core state
   input  inw_pkg::inw_prio_t level,
   input  wire logic      ibit,
   // result
   output logic           above_level,
   output logic           qualified
);
   // pure gates: this path must work while the system clock is stopped
   assign above_level = req && routed && (prio != INW_PRIO_ZERO) && (prio > level);
   assign qualified   = above_level && !ibit;
endmodule

// *** inw_top.sv ***
// interrupt nesting and wake-up qualification with its register slave
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
// Summary of operation
// - maskable requests preempt by priority; at most seven maskable routines nest.
// - while the core mask bit stays set no maskable request is presented.
// - after software clears the mask bit only higher-priority requests interrupt.
// - every core-routed maskable request of nonzero priority above the current level can wake the core from stop or wait while the mask bit is clear.
// - a machine exception request can wake the core from stop or wait.
// - mask bit set blocks every maskable request from waking the core.
// - requests at or below the current level are ignored for wake-up.
// - the non-maskable pin request wakes the core any time, mask or not.
// - pin wake with its mask set issues no vector; core resumes after sleep.
// - on vector fetch load the winning channel's priority as the new level.
// - a maskable request needs nonzero priority strictly above the current level.
module inw_top
   import inw_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              reset,
   // ahb-lite register slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // request sources
   input  wire logic [INW_NCH-1:0] chan_req,
   input  wire logic              mach_exc_req,
   input  wire logic              nonmaskable_pin_request_n,
   // core condition word and state
   input  wire logic              core_ibit,
   input  wire logic              core_xbit,
   input  inw_pkg::inw_prio_t     current_processing_level,
   input  wire logic              core_low_power,
   input  wire logic              vector_req,
   input  wire logic              return_from_service,
   // answers to the core
   output logic                   core_irq,
   output logic                   vector_valid,
   output inw_pkg::inw_vec_t      vector_kind,
   output inw_pkg::inw_chan_t     vector_chan,
   output logic                   new_level_load,
   output inw_pkg::inw_prio_t     new_level,
   output logic                   wake_req,
   output logic                   wake_resume_only
);
   import inw_pkg::*;

   typedef enum logic [1:0] {
      INW_ST_IDLE,
      INW_ST_GIVE,
      INW_ST_HOLD
   } inw_state_t;

   logic [INW_DW-1:0]  prio_cfg_reg;
   logic [INW_NCH-1:0] route_reg;
   logic               wr_pend_reg;
   logic [INW_AW-1:0]  wr_addr_reg;
   logic [31:0]        hrdata_reg;
   logic [31:0]        rd_next;
   logic               addr_phase;

   logic               pin_meta_reg;
   logic               pin_sync_reg;
   logic               pin_raw;
   logic               pin_act;

   logic [INW_NCH-1:0] above_vec;
   logic [INW_NCH-1:0] qual_vec;
   inw_prio_t          chan_prio [INW_NCH];

   logic               best_found;
   inw_chan_t          best_chan;
   inw_prio_t          best_prio;

   inw_state_t         state_reg;
   inw_vec_t           kind_reg;
   inw_chan_t          chan_reg;
   inw_prio_t          level_reg;
   logic               load_reg;
   logic [2:0]         depth_reg;
   inw_prio_t          ipl_prev_reg;
   logic               rti_wait_reg;

   // ---------------- register slave ----------------
   assign addr_phase = hsel && hready && (htrans == INW_HTRANS_NONSEQ);
   assign hreadyout  = 1'b1;
   assign hresp      = INW_HRESP_OKAY;
   assign hrdata     = hrdata_reg;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
      end else begin
         wr_pend_reg <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr_reg <= haddr[INW_AW-1:0];
         end
      end
   end

   // configuration writes land in the data phase; status is read-only
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         prio_cfg_reg <= INW_PRIO_RST;
         route_reg    <= INW_ROUTE_RST;
      end else if (wr_pend_reg) begin
         if (wr_addr_reg == INW_OFS_PRIO) begin
            prio_cfg_reg <= hwdata;
         end
         if (wr_addr_reg == INW_OFS_ROUTE) begin
            route_reg <= hwdata[INW_NCH-1:0];
         end
      end
   end

   always_comb begin
      rd_next = '0;
      unique case (haddr[INW_AW-1:0])
         INW_OFS_PRIO: begin
            rd_next = prio_cfg_reg;
         end
         INW_OFS_ROUTE: begin
            rd_next[INW_NCH-1:0] = route_reg;
         end
         INW_OFS_STATUS: begin
            rd_next[INW_ST_PEND_LSB +: INW_NCH] = qual_vec;
            rd_next[INW_ST_DEPTH_LSB +: 3]      = depth_reg;
            rd_next[INW_ST_IPL_LSB +: INW_PW]   = current_processing_level;
            rd_next[INW_ST_PIN_BIT]             = pin_act;
            rd_next[INW_ST_MACH_BIT]            = mach_exc_req;
         end
         default: begin
            rd_next = '0;
         end
      endcase
   end

   // read data is caught at the address phase so the slave never waits
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         hrdata_reg <= '0;
      end else if (addr_phase && !hwrite) begin
         hrdata_reg <= rd_next;
      end
   end

   // ---------------- pin request ----------------
   assign pin_raw = !nonmaskable_pin_request_n;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end else begin
         pin_meta_reg <= pin_raw;
         pin_sync_reg <= pin_meta_reg;
      end
   end
   assign pin_act = pin_sync_reg;

   // ---------------- channel qualification ----------------
   genvar gi;
   generate
      for (gi = 0; gi < INW_NCH; gi++) begin : g_chan
         assign chan_prio[gi] = prio_cfg_reg[gi*INW_FLD_W +: INW_PW];
         inw_chan_qual u_qual (
            .req         (chan_req[gi]),
            .routed      (route_reg[gi]),
            .prio        (chan_prio[gi]),
            .level       (current_processing_level),
            .ibit        (core_ibit),
            .above_level (above_vec[gi]),
            .qualified   (qual_vec[gi])
         );
      end
   endgenerate

   // highest priority wins, ties go to the higher channel index
   always_comb begin
      best_found = 1'b0;
      best_chan  = '0;
      best_prio  = INW_PRIO_ZERO;
      for (int i = 0; i < INW_NCH; i++) begin
         if (qual_vec[i] && (!best_found || chan_prio[i] >= best_prio)) begin
            best_found = 1'b1;
            best_chan  = inw_chan_t'(i);
            best_prio  = chan_prio[i];
         end
      end
   end

   // maskable work only reaches the core with its mask bit clear
   assign core_irq = best_found
                  || mach_exc_req
                  || (pin_act && !core_xbit);

   // ---------------- wake-up ----------------
   // raw pin and ungated qualifiers: these must act with the clock stopped
   assign wake_req = core_low_power
                  && ((|qual_vec)
                  || mach_exc_req
                  || pin_raw);
   // a pin wake with the pin mask set resumes without a vector
   assign wake_resume_only = wake_req && pin_raw && core_xbit
                          && !(|qual_vec) && !mach_exc_req;

   // ---------------- vector answer ----------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_reg <= INW_ST_IDLE;
      end else begin
         unique case (state_reg)
            INW_ST_IDLE: begin
               if (vector_req) begin
                  state_reg <= INW_ST_GIVE;
               end
            end
            INW_ST_GIVE: begin
               state_reg <= INW_ST_HOLD;
            end
            INW_ST_HOLD: begin
               if (!vector_req) begin
                  state_reg <= INW_ST_IDLE;
               end
            end
            default: begin
               state_reg <= INW_ST_IDLE;
            end
         endcase
      end
   end

   // the source is chosen when the core asks; a vanished request gives spurious
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         kind_reg  <= INW_VEC_NONE;
         chan_reg  <= '0;
         level_reg <= INW_PRIO_ZERO;
         load_reg  <= 1'b0;
      end else begin
         load_reg <= 1'b0;
         if (state_reg == INW_ST_IDLE && vector_req) begin
            if (mach_exc_req) begin
               kind_reg <= INW_VEC_MACH;
            end else if (pin_act && !core_xbit) begin
               kind_reg <= INW_VEC_PIN;
            end else if (best_found && depth_reg != INW_MAX_NEST) begin
               kind_reg  <= INW_VEC_CHAN;
               chan_reg  <= best_chan;
               level_reg <= best_prio;
               load_reg  <= 1'b1;
            end else begin
               kind_reg <= INW_VEC_SPUR;
            end
         end
      end
   end

   assign vector_valid   = (state_reg == INW_ST_GIVE);
   assign vector_kind    = kind_reg;
   assign vector_chan    = chan_reg;
   assign new_level_load = load_reg;
   assign new_level      = level_reg;

   // ---------------- nesting depth ----------------
   // a return is counted once the core's restored level drops below the old one
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ipl_prev_reg <= INW_PRIO_ZERO;
         rti_wait_reg <= 1'b0;
      end else begin
         ipl_prev_reg <= current_processing_level;
         if (return_from_service) begin
            rti_wait_reg <= 1'b1;
         end else if (rti_wait_reg) begin
            rti_wait_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         depth_reg <= INW_DEPTH_RST;
      end else if (load_reg && depth_reg != INW_MAX_NEST) begin
         depth_reg <= depth_reg + 3'h1;
      end else if ((rti_wait_reg || return_from_service)
                   && current_processing_level < ipl_prev_reg
                   && depth_reg != INW_DEPTH_RST) begin
         depth_reg <= depth_reg - 3'h1;
      end
   end

   // hsize and upper address bits are accepted but not decoded: word access only
   logic unused_ok;
   assign unused_ok = ^{hsize, haddr[31:INW_AW], above_vec};
endmodule

// *** inw_props.sv ***
// property checker for the nesting and wake-up block
`timescale 1ns/100ps
module inw_props
   import inw_pkg::*;
(
   // clock and reset
   input wire logic          ref_clk,
   input wire logic          reset,
   // core state and requests
   input wire logic          core_ibit,
   input wire logic          core_xbit,
   input wire logic          core_low_power,
   input wire logic          mach_exc_req,
   input wire logic          nonmaskable_pin_request_n,
   input wire logic          vector_req,
   // answers to the core
   input wire logic          core_irq,
   input wire logic          vector_valid,
   input inw_pkg::inw_vec_t  vector_kind,
   input wire logic          new_level_load,
   input inw_pkg::inw_prio_t new_level,
   input wire logic          wake_req,
   input wire logic          wake_resume_only
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // raw pin on purpose: the wake path must not wait for the synchroniser
   wire logic pin_on = !nonmaskable_pin_request_n;
   a_wake_masked: assert property (
      core_ibit && !mach_exc_req && !pin_on |-> !wake_req) else $error("masked wake seen");
   a_wake_mach: assert property (
      core_low_power && mach_exc_req |-> wake_req) else $error("no wake on exception");
   a_wake_pin: assert property (
      core_low_power && pin_on |-> wake_req) else $error("no wake on pin");
   a_pin_resume: assert property (
      core_low_power && pin_on && core_xbit && core_ibit && !mach_exc_req |-> wake_resume_only)
      else $error("pin wake not resume only");
   a_pin_novec: assert property (
      vector_valid && core_xbit |-> vector_kind != INW_VEC_PIN) else $error("pin vector masked");
   a_wake_awake: assert property (
      !core_low_power |-> !wake_req) else $error("wake while running");
   a_irq_masked: assert property (
      core_ibit && core_xbit && !mach_exc_req |-> !core_irq) else $error("masked irq seen");
   a_vec_answer: assert property (
      $rose(vector_req) |=> vector_valid ##1 !vector_valid) else $error("vector answer late");
   a_load_chan: assert property (
      new_level_load |-> vector_valid && vector_kind == INW_VEC_CHAN && new_level != INW_PRIO_ZERO)
      else $error("bad level load");
   c_vec_chan: cover property (vector_valid && vector_kind == INW_VEC_CHAN);
   c_pin_resume: cover property (wake_resume_only);
   c_wake_mach: cover property (wake_req && mach_exc_req);
endmodule
bind inw_top inw_props u_props (.ref_clk, .reset, .core_ibit, .core_xbit, .core_low_power,
   .mach_exc_req, .nonmaskable_pin_request_n, .vector_req, .core_irq, .vector_valid,
   .vector_kind, .new_level_load, .new_level, .wake_req, .wake_resume_only);

// *** inw_core_model.sv ***
// core-side model that asks for vectors and takes their answers
`timescale 1ns/100ps
module inw_core_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // fetch command from the bench
   input wire logic fetch,
   // vector handshake
   input wire logic vector_valid,
   output logic     vector_req
);
   // request held until the answer is seen; the source is chosen in the first cycle the request is seen
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)
         vector_req <= 1'b0;
      else if (vector_req && vector_valid)
         vector_req <= 1'b0;
      else if (fetch)
         vector_req <= 1'b1;
   end
endmodule

// *** inw_tb_top.sv ***
// self-checking bench for the nesting and wake-up block
`timescale 1ns/100ps
module inw_tb_top;
   import inw_pkg::*;
   logic        ref_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, fetch = 1'b0;
   logic        mach_exc_req = 1'b0, nonmaskable_pin_request_n = 1'b1, return_from_service = 1'b0;
   logic        core_ibit = 1'b1, core_xbit = 1'b1, core_low_power = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0;
   logic [7:0]  chan_req = 8'h00;
   inw_prio_t   current_processing_level = 3'h0, new_level;
   inw_vec_t    vector_kind;
   inw_chan_t   vector_chan;
   logic        hreadyout, hresp, core_irq, vector_valid, new_level_load, wake_req;
   logic        wake_resume_only, vector_req;
   int          failures = 0, n_tests = 0;
   inw_top uut (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .chan_req, .mach_exc_req,
      .nonmaskable_pin_request_n, .core_ibit, .core_xbit, .current_processing_level,
      .core_low_power, .vector_req, .return_from_service, .core_irq, .vector_valid,
      .vector_kind, .vector_chan, .new_level_load, .new_level, .wake_req, .wake_resume_only);
   inw_core_model core (.ref_clk, .reset, .fetch, .vector_valid, .vector_req);
   always #12.5 ref_clk = ~ref_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= INW_HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic vec(input inw_vec_t k, input logic [2:0] c);
      int n;
      n = 0;
      @(posedge ref_clk);
      fetch <= 1'b1;
      @(posedge ref_clk);
      fetch <= 1'b0;
      do begin @(negedge ref_clk); n++; end while (vector_valid !== 1'b1 && n < 20);
      chk(vector_valid, 1'b1);
      chk(vector_kind, k);
      if (k == INW_VEC_CHAN)
         chk({new_level_load, vector_chan, new_level}, {1'b1, c, c});
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic step(input logic [7:0] rq, input logic ib, input logic mx, input logic pn,
                       input logic [2:0] lv);
      @(posedge ref_clk);
      chan_req <= rq;
      core_ibit <= ib;
      mach_exc_req <= mx;
      nonmaskable_pin_request_n <= pn;
      current_processing_level <= lv;
      @(negedge ref_clk);
   endtask
   task automatic t_regs;
      logic [31:0] q;
      chk({vector_valid, vector_kind, new_level}, {1'b0, INW_VEC_NONE, 3'h0});
      bus(1'b0, INW_OFS_PRIO, 32'h0, q);
      chk(q, INW_PRIO_RST);
      bus(1'b1, INW_OFS_PRIO, 32'h7654_3210, q);
      bus(1'b1, INW_OFS_ROUTE, 32'h0000_00ff, q);
      bus(1'b1, 8'h0c, 32'hffff_ffff, q);
      bus(1'b0, INW_OFS_PRIO, 32'h0, q);
      chk(q, 32'h7654_3210);
      bus(1'b0, INW_OFS_ROUTE, 32'h0, q);
      chk(q, 32'h0000_00ff);
      bus(1'b0, 8'h0c, 32'h0, q);
      chk(q, 32'h0);
      chk(hresp, INW_HRESP_OKAY);
      $display("register test done");
   endtask
   task automatic t_wake;
      @(posedge ref_clk);
      core_low_power <= 1'b1;
      step(8'h20, 1'b1, 1'b0, 1'b1, 3'h0);
      chk({wake_req, wake_resume_only}, 2'h0);
      step(8'h20, 1'b0, 1'b0, 1'b1, 3'h5);
      chk(wake_req, 1'b0);
      step(8'h20, 1'b0, 1'b0, 1'b1, 3'h4);
      chk(wake_req, 1'b1);
      step(8'h00, 1'b1, 1'b1, 1'b1, 3'h4);
      chk(wake_req, 1'b1);
      step(8'h00, 1'b1, 1'b0, 1'b0, 3'h4);
      chk({wake_req, wake_resume_only}, 2'h3);
      step(8'h00, 1'b1, 1'b0, 1'b1, 3'h0);
      @(posedge ref_clk);
      core_low_power <= 1'b0;
      $display("wake test done");
   endtask
   task automatic t_vec;
      logic [31:0] q;
      step(8'h44, 1'b0, 1'b0, 1'b1, 3'h0);
      vec(INW_VEC_CHAN, 3'h6);
      step(8'h08, 1'b0, 1'b0, 1'b1, 3'h6);
      chk(core_irq, 1'b0);
      step(8'h80, 1'b0, 1'b0, 1'b1, 3'h6);
      chk(core_irq, 1'b1);
      step(8'h80, 1'b1, 1'b0, 1'b1, 3'h6);
      chk(core_irq, 1'b0);
      // the core restores its level in the same cycle as the return pulse
      @(posedge ref_clk);
      return_from_service <= 1'b1;
      current_processing_level <= 3'h0;
      @(posedge ref_clk);
      return_from_service <= 1'b0;
      step(8'h00, 1'b1, 1'b1, 1'b1, 3'h0);
      bus(1'b0, INW_OFS_STATUS, 32'h0, q);
      chk(q[10:8], 3'h0);
      vec(INW_VEC_MACH, 3'h0);
      core_xbit <= 1'b0;
      step(8'h00, 1'b1, 1'b0, 1'b0, 3'h0);
      repeat (3) @(posedge ref_clk);
      vec(INW_VEC_PIN, 3'h0);
      // pin still active but masked: no pin vector may be given
      @(posedge ref_clk);
      core_xbit <= 1'b1;
      repeat (3) @(posedge ref_clk);
      vec(INW_VEC_SPUR, 3'h0);
      step(8'h00, 1'b1, 1'b0, 1'b1, 3'h0);
      repeat (4) @(posedge ref_clk);
      vec(INW_VEC_SPUR, 3'h0);
      $display("vector test done");
   endtask
   task automatic t_nest;
      logic [31:0] q;
      for (int l = 1; l <= 7; l++) begin
         step(8'h01 << l, 1'b0, 1'b0, 1'b1, 3'(l - 1));
         vec(INW_VEC_CHAN, 3'(l));
      end
      step(8'h80, 1'b0, 1'b0, 1'b1, 3'h7);
      chk(core_irq, 1'b0);
      bus(1'b0, INW_OFS_STATUS, 32'h0, q);
      chk({q[14:12], q[10:8]}, 6'h3f);
      // eighth qualified request at full depth must not nest
      step(8'h80, 1'b0, 1'b0, 1'b1, 3'h6);
      vec(INW_VEC_SPUR, 3'h0);
      $display("nesting test done");
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      t_regs;
      t_wake;
      t_vec;
      t_nest;
      end_of_test;
   end
   initial begin
      #200000;
      failures++;
      end_of_test;
   end
endmodule
